// [logic/rct_pkg.sv]
// shared constants, types and lookup tables of the relay channel timer
package rct_pkg;
   // clock and time base
   localparam int CLK_NS = 5;                   // device clock period
   localparam int TICK_NS = 500_000_000;        // time base tick, 0.5 s
   localparam int PRE_CYC = TICK_NS / CLK_NS;   // clock cycles per tick
   localparam int PRE_W = 27;                   // prescaler width
   localparam int TICK_MS = 500;                // tick length in ms
   localparam int WARN_MS = 30_000;             // warning lead time
   localparam int DARK_MS = 1_000;              // blink off phase
   localparam int LIT_MS = 10_000;              // blink on phase
   localparam int CNT_W = 15;                   // tick counter width
   localparam logic [CNT_W-1:0] WARN_T = CNT_W'(WARN_MS / TICK_MS);
   localparam logic [4:0] DARK_T = 5'(DARK_MS / TICK_MS);
   localparam logic [4:0] LIT_T = 5'(LIT_MS / TICK_MS);
   localparam logic [1:0] BLINK_LAST = 2'h2;    // third dark/lit pair

   // register byte addresses
   localparam logic [7:0] ADR_CFG = 8'h00;      // modes and options
   localparam logic [7:0] ADR_TIME = 8'h04;     // delay and period selects
   localparam logic [7:0] ADR_SCA = 8'h08;      // scene assignments 0..3
   localparam logic [7:0] ADR_SCB = 8'h0C;      // scene assignments 4..7
   localparam logic [7:0] ADR_STAT = 8'h10;     // channel state, read only

   // field positions of the configuration register
   localparam int F_MODE = 0;                   // operating mode bit
   localparam int F_LOP = 1;                    // logic operation, 2 bits
   localparam int F_RSW = 3;                    // switch restore, 2 bits
   localparam int F_RLG = 5;                    // logic restore, 2 bits
   localparam int F_BLK = 7;                    // blink warning enable
   localparam int F_NSEL = 8;                   // night period, 4 bits
   // field positions of the time register
   localparam int F_OND = 0;                    // on delay select
   localparam int F_OFFD = 8;                   // off delay select
   localparam int F_ONTM = 16;                  // time switch period
   // scene assignment fields are one byte apart
   localparam int F_SCW = 8;                    // byte pitch
   localparam int SC_N = 8;                     // assignments per channel

   // field encodings
   localparam logic MODE_NORM = 1'h0;           // normal switch
   localparam logic MODE_TSW = 1'h1;            // time switch
   localparam logic [1:0] LOP_NONE = 2'h0;      // no logic operation
   localparam logic [1:0] LOP_AND = 2'h1;       // and with logic object
   localparam logic [1:0] LOP_OR = 2'h2;        // or with logic object
   localparam logic [1:0] RST_SAVED = 2'h0;     // as before failure
   localparam logic [1:0] RST_ON = 2'h2;        // on (1 and 3 mean off)

   // values after reset
   localparam logic [3:0] NSEL_RST = 4'h8;      // 30 minutes
   localparam logic [4:0] ONTM_RST = 5'h13;     // 5 minutes
   localparam int NSEL_OFS = 16;                // night table base index

   // pending delay and blink warning states
   typedef enum logic [1:0] {P_NONE, P_ON, P_OFF} rct_pend_e;
   typedef enum logic [1:0] {BL_IDLE, BL_DARK, BL_LIT} rct_blink_e;

   // delay select to half-second ticks, 0 means disabled
   function automatic logic [CNT_W-1:0] rct_ticks(input logic [4:0] sel);
      case (sel)
         5'h01: rct_ticks = 15'h0001;
         5'h02: rct_ticks = 15'h0002;
         5'h03: rct_ticks = 15'h0004;
         5'h04: rct_ticks = 15'h0006;
         5'h05: rct_ticks = 15'h0008;
         5'h06: rct_ticks = 15'h000A;
         5'h07: rct_ticks = 15'h0010;
         5'h08: rct_ticks = 15'h0014;
         5'h09: rct_ticks = 15'h0018;
         5'h0A: rct_ticks = 15'h001E;
         5'h0B: rct_ticks = 15'h0028;
         5'h0C: rct_ticks = 15'h0032;
         5'h0D: rct_ticks = 15'h003C;
         5'h0E: rct_ticks = 15'h005A;
         5'h0F: rct_ticks = 15'h0078;
         5'h10: rct_ticks = 15'h00B4;
         5'h11: rct_ticks = 15'h00F0;
         5'h12: rct_ticks = 15'h0168;
         5'h13: rct_ticks = 15'h0258;
         5'h14: rct_ticks = 15'h03C0;
         5'h15: rct_ticks = 15'h04B0;
         5'h16: rct_ticks = 15'h0708;
         5'h17: rct_ticks = 15'h0960;
         5'h18: rct_ticks = 15'h0E10;
         5'h19: rct_ticks = 15'h1518;
         5'h1A: rct_ticks = 15'h1C20;
         5'h1B: rct_ticks = 15'h2A30;
         default: rct_ticks = 15'h0000;
      endcase
   endfunction

   // value taken after mains recovery
   function automatic logic rct_restore(input logic [1:0] sel,
                                        input logic saved);
      case (sel)
         RST_SAVED: rct_restore = saved;
         RST_ON: rct_restore = 1'b1;
         default: rct_restore = 1'b0;
      endcase
   endfunction
endpackage

// [logic/rct_tmr.sv]
// loadable down counter of time base ticks with an end pulse
`timescale 1ns/1ps
module rct_tmr import rct_pkg::*; #(
   parameter int W = CNT_W
) (
   clk, // device clock
   rstn, // asynchronous reset, active low
   ce, // clock enable, freezes state when low
   load, // load val this cycle
   clr, // stop the count
   val, // ticks to count
   tick, // time base tick
   cnt, // remaining ticks
   done // one cycle pulse when the count ran out
);
   input wire logic clk;
   input wire logic rstn;
   input wire logic ce;
   input wire logic load;
   input wire logic clr;
   input wire logic [W-1:0] val;
   input wire logic tick;
   output logic [W-1:0] cnt;
   output logic done;

   typedef struct packed {
      logic [W-1:0] cnt; // remaining ticks
      logic done; // end pulse
   } rct_tmr_s;

   rct_tmr_s st_ff; // all state
   rct_tmr_s nxt_st; // next state

   // count down one per tick, load and clear take priority
   always_comb begin
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      if (load) begin
         nxt_st.cnt = val;
      end else if (clr) begin
         nxt_st.cnt = '0;
      end else if (tick && st_ff.cnt != '0) begin
         nxt_st.cnt = st_ff.cnt - W'(1);
         nxt_st.done = (st_ff.cnt == W'(1));
      end
   end

   // state register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign cnt = st_ff.cnt;
   assign done = st_ff.done;
endmodule

// [logic/rct_chan.sv]
// one relay channel: delays, time switch, night mode, blink, scenes, mains
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
// Operation
// - normal mode or time switch mode
// - optional and/or with undelayed logic object
// - on delay for switch object only
// - off delay for switch object only
// - mains failure saves state, forces off
// - no logic: configured state after recovery
// - normal with logic: both objects restored independently
// - night mode limits on period
// - new on command reloads running period
// - blink warning three times before off
// - time switch period, auto off
// - time switch with logic restores logic object
// - eight scene assignments, zero unused
// - unprogrammed scene recall switches off
// - scene byte: number, program bit, zero bit
// - night object one enters, zero leaves
// - timer stage first operand, logic second
module rct_chan import rct_pkg::*; #(
   parameter int PRE_CYCLES = PRE_CYC
) (
   clk, // device clock, 200 MHz
   rstn, // asynchronous reset, active low
   ce, // clock enable, freezes all state when low
   reg_addr, // register byte address
   reg_wdata, // register write data
   reg_wr, // register write strobe
   reg_rd, // register read strobe
   reg_rdata, // read data, cycle after the read strobe
   sw_stb, // switch object telegram
   sw_val, // switch object value
   lg_stb, // logic object telegram
   lg_val, // logic object value
   nt_stb, // night mode object telegram
   nt_val, // night mode object value
   sc_stb, // scene telegram
   sc_byte, // scene byte
   mains_ok, // mains present, asynchronous pin
   relay_on // relay drive
);
   input wire logic clk;
   input wire logic rstn;
   input wire logic ce;
   input wire logic [7:0] reg_addr;
   input wire logic [31:0] reg_wdata;
   input wire logic reg_wr;
   input wire logic reg_rd;
   output logic [31:0] reg_rdata;
   input wire logic sw_stb;
   input wire logic sw_val;
   input wire logic lg_stb;
   input wire logic lg_val;
   input wire logic nt_stb;
   input wire logic nt_val;
   input wire logic sc_stb;
   input wire logic [7:0] sc_byte;
   input wire logic mains_ok;
   output logic relay_on;

   typedef struct packed {
      logic [PRE_W-1:0] pre; // prescaler count
      logic tick; // time base pulse
      logic mok1; // mains synchroniser first stage
      logic mok2; // mains synchroniser second stage
      logic mok_prev; // mains level one cycle earlier
      logic up; // channel powered and active
      logic stage; // timer stage output
      logic lobj; // logic object value
      logic night; // night mode active
      logic sv_sw; // saved switch state
      logic sv_lg; // saved logic object
      logic out; // relay drive
      rct_pend_e pend; // pending delayed command
      rct_blink_e bl; // blink warning state
      logic [4:0] bcnt; // blink phase ticks
      logic [1:0] brep; // blink pair number
      logic mode; // operating mode
      logic [1:0] lop; // logic operation
      logic [1:0] rsw; // switch restore select
      logic [1:0] rlg; // logic restore select
      logic blk_en; // blink warning enable
      logic [3:0] nsel; // night period select
      logic [4:0] ond; // on delay select
      logic [4:0] offd; // off delay select
      logic [4:0] ontm; // time switch period select
      logic [SC_N-1:0][6:0] asg; // scene assignments
      logic [SC_N-1:0] scv; // scene stored states
      logic [SC_N-1:0] scp; // scene programmed flags
      logic [31:0] rdata; // read data
   } rct_st_s;

   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRE_CYCLES - 1);

   rct_st_s st_ff; // all state
   rct_st_s nxt_st; // next state
   logic dly_load, dly_clr, dly_done; // delay timer control
   logic per_load, per_clr, per_done; // period timer control
   logic [CNT_W-1:0] dly_val, per_val, per_cnt; // timer values
   logic timed; // an on period applies
   logic act_en, act_v; // switch the stage now, to act_v
   logic stage_r; // stage value after recovery
   logic hit, hit_v; // scene recall found, its state
   logic [6:0] scn; // received scene number

   // delay timer for on and off delays
   rct_tmr #(.W(CNT_W)) u_dly (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .load(dly_load),
      .clr(dly_clr),
      .val(dly_val),
      .tick(st_ff.tick),
      .cnt(),
      .done(dly_done)
   );

   // period timer for night and time switch on periods
   rct_tmr #(.W(CNT_W)) u_per (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .load(per_load),
      .clr(per_clr),
      .val(per_val),
      .tick(st_ff.tick),
      .cnt(per_cnt),
      .done(per_done)
   );

   // next state of the whole channel
   always_comb begin
      nxt_st = st_ff;
      dly_load = 1'b0;
      dly_clr = 1'b0;
      dly_val = '0;
      per_load = 1'b0;
      per_clr = 1'b0;
      act_en = 1'b0;
      act_v = 1'b0;
      stage_r = 1'b0;
      hit = 1'b0;
      hit_v = 1'b0;
      scn = {1'b0, sc_byte[5:0]} + 7'h01;
      // period length depends on mode
      per_val = (st_ff.mode == MODE_TSW) ? rct_ticks(st_ff.ontm) :
                rct_ticks(5'(NSEL_OFS) + {1'b0, st_ff.nsel});
      timed = (st_ff.mode == MODE_TSW) ? (st_ff.ontm != 5'h00) :
              st_ff.night;
      // common half-second time base
      nxt_st.tick = 1'b0;
      if (st_ff.pre == PRE_LAST) begin
         nxt_st.pre = '0;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.pre = st_ff.pre + PRE_W'(1);
      end
      // mains level synchroniser
      nxt_st.mok1 = mains_ok;
      nxt_st.mok2 = st_ff.mok1;
      nxt_st.mok_prev = st_ff.mok2;
      // register writes
      if (reg_wr) begin
         case (reg_addr)
            ADR_CFG: begin
               nxt_st.mode = reg_wdata[F_MODE];
               nxt_st.lop = reg_wdata[F_LOP +: 2];
               nxt_st.rsw = reg_wdata[F_RSW +: 2];
               nxt_st.rlg = reg_wdata[F_RLG +: 2];
               nxt_st.blk_en = reg_wdata[F_BLK];
               nxt_st.nsel = reg_wdata[F_NSEL +: 4];
            end
            ADR_TIME: begin
               nxt_st.ond = reg_wdata[F_OND +: 5];
               nxt_st.offd = reg_wdata[F_OFFD +: 5];
               nxt_st.ontm = reg_wdata[F_ONTM +: 5];
            end
            ADR_SCA: begin
               for (int i = 0; i < 4; i++) begin
                  nxt_st.asg[i] = reg_wdata[i*F_SCW +: 7];
               end
            end
            ADR_SCB: begin
               for (int i = 0; i < 4; i++) begin
                  nxt_st.asg[i+4] = reg_wdata[i*F_SCW +: 7];
               end
            end
            default: begin
               // unmapped writes are ignored
            end
         endcase
      end
      // register reads, data valid the next cycle only
      nxt_st.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            ADR_CFG: begin
               nxt_st.rdata = {20'h0_0000, st_ff.nsel, st_ff.blk_en,
                               st_ff.rlg, st_ff.rsw, st_ff.lop, st_ff.mode};
            end
            ADR_TIME: begin
               nxt_st.rdata = {11'h000, st_ff.ontm, 3'h0, st_ff.offd,
                               3'h0, st_ff.ond};
            end
            ADR_SCA: begin
               for (int i = 0; i < 4; i++) begin
                  nxt_st.rdata[i*F_SCW +: 7] = st_ff.asg[i];
               end
            end
            ADR_SCB: begin
               for (int i = 0; i < 4; i++) begin
                  nxt_st.rdata[i*F_SCW +: 7] = st_ff.asg[i+4];
               end
            end
            ADR_STAT: begin
               nxt_st.rdata = {16'h0000, st_ff.scp, 1'b0, st_ff.mok2,
                               st_ff.bl != BL_IDLE, st_ff.pend != P_NONE,
                               st_ff.night, st_ff.lobj, st_ff.stage,
                               st_ff.out};
            end
            default: begin
               nxt_st.rdata = '0; // unmapped reads return zero
            end
         endcase
      end
      if (st_ff.mok2 && !st_ff.mok_prev) begin
         // mains came back: restore configured states
         nxt_st.up = 1'b1;
         if (st_ff.mode == MODE_TSW && st_ff.lop != LOP_NONE) begin
            stage_r = 1'b0;
         end else begin
            stage_r = rct_restore(st_ff.rsw, st_ff.sv_sw);
         end
         if (st_ff.lop != LOP_NONE) begin
            nxt_st.lobj = rct_restore(st_ff.rlg, st_ff.sv_lg);
         end
         act_en = 1'b1;
         act_v = stage_r;
      end else if (!st_ff.mok2 && st_ff.mok_prev) begin
         // mains lost: save first, then drop stage, pending command, blink and timers
         nxt_st.sv_sw = st_ff.stage;
         nxt_st.sv_lg = st_ff.lobj;
         nxt_st.up = 1'b0;
         nxt_st.stage = 1'b0;
         nxt_st.pend = P_NONE;
         nxt_st.bl = BL_IDLE;
         dly_clr = 1'b1;
         per_clr = 1'b1;
      end else if (st_ff.up) begin
         // delayed command comes due
         if (dly_done && st_ff.pend != P_NONE) begin
            act_en = 1'b1;
            act_v = (st_ff.pend == P_ON);
            nxt_st.pend = P_NONE;
         end
         // blink warning sequence before the period ends
         case (st_ff.bl)
            BL_IDLE: begin
               if (st_ff.blk_en && st_ff.stage && st_ff.tick &&
                   per_cnt == WARN_T) begin
                  nxt_st.bl = BL_DARK;
                  nxt_st.bcnt = DARK_T;
                  nxt_st.brep = 2'h0;
                  per_clr = 1'b1;
               end else if (per_done) begin
                  act_en = 1'b1;
                  act_v = 1'b0;
               end
            end
            BL_DARK: begin
               if (st_ff.tick) begin
                  if (st_ff.bcnt == 5'h01) begin
                     nxt_st.bl = BL_LIT;
                     nxt_st.bcnt = LIT_T;
                  end else begin
                     nxt_st.bcnt = st_ff.bcnt - 5'h01;
                  end
               end
            end
            BL_LIT: begin
               if (st_ff.tick) begin
                  if (st_ff.bcnt != 5'h01) begin
                     nxt_st.bcnt = st_ff.bcnt - 5'h01;
                  end else if (st_ff.brep == BLINK_LAST) begin
                     act_en = 1'b1;
                     act_v = 1'b0;
                  end else begin
                     nxt_st.brep = st_ff.brep + 2'h1;
                     nxt_st.bl = BL_DARK;
                     nxt_st.bcnt = DARK_T;
                  end
               end
            end
            default: begin
               nxt_st.bl = BL_IDLE;
            end
         endcase
         // switch object telegram
         if (sw_stb) begin
            if (st_ff.mode == MODE_TSW) begin
               if (sw_val) begin
                  act_en = 1'b1;
                  act_v = 1'b1;
               end
            end else if (sw_val) begin
               if (st_ff.ond == 5'h00) begin
                  act_en = 1'b1;
                  act_v = 1'b1;
                  nxt_st.pend = P_NONE;
                  dly_clr = 1'b1;
               end else if (st_ff.pend != P_ON) begin
                  nxt_st.pend = P_ON;
                  dly_load = 1'b1;
                  dly_val = rct_ticks(st_ff.ond);
               end
            end else begin
               if (st_ff.offd == 5'h00) begin
                  act_en = 1'b1;
                  act_v = 1'b0;
                  nxt_st.pend = P_NONE;
                  dly_clr = 1'b1;
               end else if (st_ff.pend != P_OFF) begin
                  nxt_st.pend = P_OFF;
                  dly_load = 1'b1;
                  dly_val = rct_ticks(st_ff.offd);
               end
            end
         end
         // logic object takes effect at once
         if (lg_stb) begin
            nxt_st.lobj = lg_val;
         end
         // night mode object
         if (nt_stb) begin
            nxt_st.night = nt_val;
            if (st_ff.mode == MODE_NORM) begin
               if (nt_val && st_ff.stage && !st_ff.night) begin
                  per_load = 1'b1;
               end else if (!nt_val) begin
                  per_clr = 1'b1;
                  nxt_st.bl = BL_IDLE;
               end
            end
         end
         // scene telegram; bit 6 set marks a malformed byte
         if (sc_stb && !sc_byte[6]) begin
            for (int i = 0; i < SC_N; i++) begin
               if (st_ff.asg[i] != 7'h00 && st_ff.asg[i] == scn) begin
                  if (sc_byte[7]) begin
                     nxt_st.scv[i] = st_ff.stage;
                     nxt_st.scp[i] = 1'b1;
                  end else if (!hit) begin
                     hit = 1'b1;
                     hit_v = st_ff.scp[i] & st_ff.scv[i];
                  end
               end
            end
            if (hit) begin
               act_en = 1'b1;
               act_v = hit_v;
            end
         end
      end
      // stage switching, on reloads the period
      if (act_en) begin
         nxt_st.stage = act_v;
         nxt_st.bl = BL_IDLE;
         if (act_v && timed) begin
            per_load = 1'b1;
            per_clr = 1'b0;
         end else if (!act_v) begin
            per_clr = 1'b1;
            per_load = 1'b0;
         end
      end
      // stage first operand, logic object second
      case (st_ff.lop)
         LOP_AND: begin
            nxt_st.out = (nxt_st.stage && nxt_st.bl != BL_DARK) &&
                         nxt_st.lobj;
         end
         LOP_OR: begin
            nxt_st.out = (nxt_st.stage && nxt_st.bl != BL_DARK) ||
                         nxt_st.lobj;
         end
         default: begin
            nxt_st.out = nxt_st.stage && nxt_st.bl != BL_DARK;
         end
      endcase
      if (!nxt_st.up) begin
         nxt_st.out = 1'b0;
      end
   end

   // state register, frozen while ce is low
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= '0;
         st_ff.nsel <= NSEL_RST;
         st_ff.ontm <= ONTM_RST;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata = st_ff.rdata;
   assign relay_on = st_ff.out;
endmodule

// [bench/rct_bus_dev.sv]
// bus sender model: switch, logic, night and scene telegrams
`timescale 1ns/1ps
module rct_bus_dev (
   input wire logic clk, // device clock
   output logic sw_stb, // switch telegram
   output logic sw_val, // switch value
   output logic lg_stb, // logic telegram
   output logic lg_val, // logic value
   output logic nt_stb, // night telegram
   output logic nt_val, // night value
   output logic sc_stb, // scene telegram
   output logic [7:0] sc_byte // scene byte
);
   initial begin
      {sw_stb, sw_val, lg_stb, lg_val, nt_stb, nt_val, sc_stb} = 7'h00;
      sc_byte = 8'h00;
   end
   // one telegram, k: 0 switch, 1 logic, 2 night, 3 scene
   task automatic send(input int k, input logic [7:0] v);
      @(posedge clk);
      {sw_stb, lg_stb, nt_stb, sc_stb} <= 4'h8 >> k;
      {sw_val, lg_val, nt_val} <= {3{v[0]}};
      sc_byte <= v;
      @(posedge clk);
      {sw_stb, lg_stb, nt_stb, sc_stb} <= 4'h0;
      // released lines flip so a stale value is never reused
      {sw_val, lg_val, nt_val} <= ~{sw_val, lg_val, nt_val};
      sc_byte <= ~v;
   endtask
endmodule

// [bench/rct_chan_checker.sv]
// port assertions of the relay channel
`timescale 1ns/1ps
module rct_chan_checker import rct_pkg::*; #(
   parameter int PRE_CYCLES = PRE_CYC // tick prescale
) (
   input wire logic clk, // clock
   input wire logic rstn, // reset, active low
   input wire logic ce, // clock enable
   input wire logic [7:0] reg_addr, // address
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   input wire logic [31:0] reg_rdata, // read data
   input wire logic mains_ok, // mains present
   input wire logic relay_on // relay drive
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   AST_MAINS_OFF: assert property (!mains_ok [*4] |-> !relay_on)
      else $error("relay on without mains");
   AST_RECOVER: assert property (
      $rose(mains_ok) && !relay_on |-> !relay_on [*3])
      else $error("relay early after recovery");
   AST_FREEZE: assert property (!ce |=> $stable(relay_on))
      else $error("relay moved with enable low");
   AST_RD_IDLE: assert property (
      !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside slot");
   AST_UNMAPPED: assert property (
      ce && reg_rd && reg_addr == 8'h14 |=> reg_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   AST_CFG_RB: assert property (
      ce && reg_wr && reg_addr == ADR_CFG ##1
      ce && reg_rd && reg_addr == ADR_CFG
      |=> reg_rdata == {20'h0_0000, $past(reg_wdata[11:0], 2)})
      else $error("config readback wrong");
   AST_TIME_RB: assert property (
      ce && reg_wr && reg_addr == ADR_TIME ##1
      ce && reg_rd && reg_addr == ADR_TIME
      |=> reg_rdata == {11'h000, $past(reg_wdata[20:16], 2), 3'h0,
      $past(reg_wdata[12:8], 2), 3'h0, $past(reg_wdata[4:0], 2)})
      else $error("time readback wrong");
   AST_STAT: assert property (
      ce && reg_rd && reg_addr == ADR_STAT ##1 $stable(relay_on)
      |-> reg_rdata[0] == relay_on)
      else $error("status bit differs from relay");
endmodule
bind rct_chan rct_chan_checker #(.PRE_CYCLES(PRE_CYCLES)) chk_u (.clk,
   .rstn, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .mains_ok, .relay_on);

// [bench/rct_chan_tb.sv]
// self-checking bench for one relay channel
`timescale 1ns/1ps
module rct_chan_tb import rct_pkg::*; ;
   logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, mains_ok = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, relay_on;
   logic [7:0] reg_addr = 8'h00, sc_byte;
   logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
   logic sw_stb, sw_val, lg_stb, lg_val, nt_stb, nt_val, sc_stb;
   int fails = 0, total_checks = 0, n;
   always #2.5 clk = ~clk;
   rct_chan #(.PRE_CYCLES(4)) dut_u (.clk, .rstn, .ce, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sw_stb, .sw_val, .lg_stb,
      .lg_val, .nt_stb, .nt_val, .sc_stb, .sc_byte, .mains_ok, .relay_on);
   rct_bus_dev dev_u (.clk, .sw_stb, .sw_val, .lg_stb, .lg_val, .nt_stb,
      .nt_val, .sc_stb, .sc_byte);
   task automatic chk(input logic [31:0] seen, exp, input string nm);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   // bus tasks start just after an edge, end 1 ns past the taking edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e, "register");
   endtask
   task automatic rl(input logic e);
      chk({31'h0, relay_on}, {31'h0, e}, "relay");
   endtask
   task automatic tg(input int k, input logic [7:0] v);
      dev_u.send(k, v);
      cyc(2);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // watchdog: the tests need about 1500 cycles
   initial begin
      #100_000;
      fails++;
      finish_test;
   end
   initial begin
      cyc(20);
      rstn <= 1'b1;
      rd(ADR_CFG, 32'h0000_0800);
      rd(ADR_TIME, 32'h0013_0000);
      rd(8'h14, 32'h0000_0000);
      mains_ok <= 1'b1;
      cyc(8);
      wr(ADR_CFG, 32'h0000_0800);
      rd(ADR_CFG, 32'h0000_0800);
      wr(ADR_TIME, 32'h0000_0000);
      tg(0, 8'h01);
      rl(1);
      tg(0, 8'h00);
      rl(0);
      // four tick on and off delays
      wr(ADR_TIME, 32'h0000_0303);
      rd(ADR_TIME, 32'h0000_0303);
      tg(0, 8'h01);
      cyc(9);
      rl(0);
      cyc(9);
      rl(1);
      tg(0, 8'h00);
      rl(1);
      cyc(18);
      rl(0);
      tg(0, 8'h01);
      cyc(4);
      tg(0, 8'h00);
      cyc(24);
      rl(0);
      // logic object, undelayed, and then or
      wr(ADR_TIME, 32'h0000_0000);
      wr(ADR_CFG, 32'h0000_0802);
      tg(1, 8'h00);
      tg(0, 8'h01);
      rl(0);
      tg(1, 8'h01);
      rl(1);
      wr(ADR_CFG, 32'h0000_0804);
      tg(0, 8'h00);
      rl(1);
      tg(1, 8'h00);
      rl(0);
      // time switch, six tick period, retrigger
      wr(ADR_CFG, 32'h0000_0801);
      wr(ADR_TIME, 32'h0004_0000);
      tg(0, 8'h01);
      tg(0, 8'h00);
      rl(1);
      cyc(10);
      tg(0, 8'h01);
      cyc(12);
      rl(1);
      cyc(16);
      rl(0);
      // blink warning on a 90 tick period
      wr(ADR_CFG, 32'h0000_0881);
      wr(ADR_TIME, 32'h000E_0000);
      n = 0;
      tg(0, 8'h01);
      fork
         forever @(negedge relay_on) n++;
      join_none
      cyc(420);
      disable fork;
      chk(n, 32'h0000_0004, "falls");
      // night mode, 1.5 minute limit
      wr(ADR_CFG, 32'h0000_0000);
      wr(ADR_TIME, 32'h0000_0000);
      tg(2, 8'h01);
      tg(0, 8'h01);
      cyc(690);
      rl(1);
      cyc(40);
      rl(0);
      tg(2, 8'h00);
      tg(0, 8'h01);
      ce <= 1'b0;
      tg(0, 8'h00);
      rl(1);
      ce <= 1'b1;
      // every switch restore code, then logic restore on, after a mains failure
      for (int c = 0; c < 5; c++) begin
         wr(ADR_CFG, c < 4 ? 32'(c) << F_RSW : 32'h0000_004C);
         tg(0, 8'h01);
         mains_ok <= 1'b0;
         cyc(6);
         rl(0);
         mains_ok <= 1'b1;
         cyc(8);
         rl(c % 2 == 0);
      end
      wr(ADR_CFG, 32'h0000_0000);
      // scene 5 in assignment one
      wr(ADR_SCA, 32'h0000_0005);
      tg(0, 8'h01);
      tg(3, 8'h04);
      rl(0);
      tg(0, 8'h01);
      tg(3, 8'h84);
      tg(0, 8'h00);
      tg(3, 8'h04);
      rl(1);
      tg(0, 8'h00);
      tg(3, 8'h44);
      rl(0);
      tg(0, 8'h01);
      tg(3, 8'h05);
      rl(1);
      rd(ADR_STAT, 32'h0000_0147);
      finish_test;
   end
endmodule
